// ---- logic/pmbp_pkg.sv ----
// constants for the program memory block protection logic
package pmbp_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;
    localparam int REGIONS = 5;
    // region ends (inclusive) and memory size limits (first address past the end)
    localparam logic [21:0] BOOT_END = 22'h0001ff;
    localparam logic [21:0] R0_END = 22'h001fff;
    localparam logic [21:0] R1_END = 22'h003fff;
    localparam logic [21:0] R2_END = 22'h005fff;
    localparam logic [21:0] R3_END = 22'h007fff;
    localparam logic [21:0] SMALL_LIMIT = 22'h004000;
    localparam logic [21:0] LARGE_LIMIT = 22'h008000;
    // configuration byte addresses
    localparam logic [21:0] CFG_EXT_LOW = 22'h300008;
    localparam logic [21:0] CFG_EXT_HIGH = 22'h300009;
    localparam logic [21:0] CFG_WR_LOW = 22'h30000a;
    localparam logic [21:0] CFG_WR_HIGH = 22'h30000b;
    localparam logic [21:0] CFG_RD_LOW = 22'h30000c;
    localparam logic [21:0] CFG_RD_HIGH = 22'h30000d;
    localparam logic [21:0] DEVID_LOW = 22'h3ffffe;
    localparam logic [21:0] DEVID_HIGH = 22'h3fffff;
    // identification word, value arbitrary
    localparam logic [15:0] DEVICE_ID = 16'h5a01;
    // opcode decode
    localparam logic [13:0] TBL_PREFIX = 14'h0002;
    localparam logic [13:0] TBW_PREFIX = 14'h0003;
    localparam logic [1:0] PTR_NONE = 2'h0;
    localparam logic [1:0] PTR_POSTINC = 2'h1;
    localparam logic [1:0] PTR_POSTDEC = 2'h2;
    localparam logic [1:0] PTR_PREINC = 2'h3;
    // field positions
    localparam int LOW_W = 4;
    localparam int BOOT_BIT = 6;
    localparam int EEP_BIT = 7;
    localparam int CFGWR_BIT = 5;
    localparam logic [7:0] LOW_MASK = 8'h0f;
    localparam logic [7:0] EXT_HIGH_MASK = 8'hc0;
    localparam logic [7:0] WR_HIGH_MASK = 8'he0;
    localparam logic [7:0] RD_HIGH_MASK = 8'h40;
    localparam logic [2:0] NO_REGION = 3'h7;
    localparam logic [2:0] BOOT_REGION = 3'h4;
    typedef enum logic [2:0] {
        PMBP_IDLE = 3'b001,
        PMBP_EXEC = 3'b010,
        PMBP_PROG = 3'b100
    } pmbp_state_t;
endpackage

// ---- logic/pmbp_region_decode.sv ----
// maps a program address to its protection region
module pmbp_region_decode
    import pmbp_pkg::*;
(
    // address in
    input wire logic [pmbp_pkg::ADDR_W-1:0] addr,
    input wire logic large_mem,
    // region out: 0..3 blocks, 4 boot, 7 none
    output logic [2:0] region
);
    wire logic above = large_mem ? (addr >= LARGE_LIMIT)
                                 : (addr >= SMALL_LIMIT);
    assign region = above ? NO_REGION :
                    (addr <= BOOT_END) ? BOOT_REGION :
                    (addr <= R0_END) ? 3'h0 :
                    (addr <= R1_END) ? 3'h1 :
                    (addr <= R2_END) ? 3'h2 :
                    (addr <= R3_END) ? 3'h3 : NO_REGION;
endmodule

// ---- logic/pmbp_fuse_reg.sv ----
// one protection byte: clears only, erase sets back to ones
module pmbp_fuse_reg
    import pmbp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // access
    input wire logic wr_en,
    input wire logic [pmbp_pkg::DATA_W-1:0] wr_data,
    input wire logic erase,
    input wire logic [pmbp_pkg::DATA_W-1:0] mask,
    // state
    output logic [pmbp_pkg::DATA_W-1:0] value
);
    logic [DATA_W-1:0] next_value;
    // a written 1 can never raise a bit that is already 0
    assign next_value = erase ? mask :
                        wr_en ? (value & wr_data & mask) : value;
    // erased (unprotected) after reset; real silicon keeps it in flash
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            value <= 8'hff & mask;
        end else begin
            value <= next_value;
        end
    end
    a_only_clears: assert property (
        @(posedge sys_clk) disable iff (reset)
        !erase |=> (value & ~$past(value)) == 8'h00)
        else $error("protection bit rose without erase");
endmodule

// ---- logic/pmbp_core.sv ----
// table access checker with protection configuration bytes
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module pmbp_core
    import pmbp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // memory size strap: 1 for the larger memory
    input wire logic large_mem,
    // core instruction path
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [pmbp_pkg::ADDR_W-1:0] pc,
    input wire logic [pmbp_pkg::ADDR_W-1:0] tbl_ptr,
    input wire logic [pmbp_pkg::DATA_W-1:0] tbl_wdata,
    // flash array
    input wire logic [pmbp_pkg::DATA_W-1:0] mem_rdata,
    input wire logic prog_done,
    // external programmer
    input wire logic ext_valid,
    input wire logic ext_write,
    input wire logic [pmbp_pkg::ADDR_W-1:0] ext_addr,
    input wire logic [pmbp_pkg::DATA_W-1:0] ext_wdata,
    input wire logic ext_chip_erase,
    input wire logic ext_block_erase,
    input wire logic [2:0] ext_erase_region,
    // results to core
    output logic [pmbp_pkg::DATA_W-1:0] tbl_rdata,
    output logic tbl_rdone,
    output logic [pmbp_pkg::ADDR_W-1:0] tbl_ptr_next,
    output logic tbl_ptr_load,
    output logic tbl_wr_refused,
    // memory control
    output logic mem_prog,
    output logic [pmbp_pkg::ADDR_W-1:0] mem_addr,
    output logic [pmbp_pkg::DATA_W-1:0] mem_wdata,
    // results to programmer
    output logic [pmbp_pkg::DATA_W-1:0] ext_rdata,
    output logic ext_rdone,
    output logic ext_refused,
    output logic busy
);
    pmbp_state_t state, next_state;
    logic [1:0] ptr_mode;
    logic is_write;
    logic [ADDR_W-1:0] op_addr;
    logic [2:0] exec_region;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] step_ptr(
        input logic [ADDR_W-1:0] p, input logic [1:0] m);
        case (m)
            PTR_POSTINC, PTR_PREINC: step_ptr = p + 22'h000001;
            PTR_POSTDEC: step_ptr = p - 22'h000001;
            default: step_ptr = p;
        endcase
    endfunction

    function automatic logic cfg_hit(input logic [ADDR_W-1:0] a);
        cfg_hit = (a >= CFG_EXT_LOW) && (a <= CFG_RD_HIGH);
    endfunction

    wire logic is_table_read_instr = instr[15:2] == TBL_PREFIX;
    wire logic is_table_write_instr = instr[15:2] == TBW_PREFIX;
    wire logic start = (state == PMBP_IDLE) && instr_valid
                       && (is_table_read_instr || is_table_write_instr);
    wire logic [1:0] mode_in = instr[1:0];
    // pre-increment uses the stepped pointer for this access
    wire logic [ADDR_W-1:0] addr_in = (mode_in == PTR_PREINC)
                                      ? step_ptr(tbl_ptr, mode_in)
                                      : tbl_ptr;

    logic [2:0] tgt_region, pc_region, ext_region;
    pmbp_region_decode u_tgt (
        .addr(op_addr), .large_mem(large_mem), .region(tgt_region));
    pmbp_region_decode u_pc (
        .addr(pc), .large_mem(large_mem), .region(pc_region));
    pmbp_region_decode u_ext (
        .addr(ext_addr), .large_mem(large_mem), .region(ext_region));

    // ---------------------------------------------------------------
    // configuration bytes
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] cfg_ext_lo, cfg_ext_hi, cfg_wr_lo, cfg_wr_hi;
    logic [DATA_W-1:0] cfg_rd_lo, cfg_rd_hi;
    wire logic erase_any = ext_chip_erase || ext_block_erase;
    // only the programmer port drives erase; user code cannot
    wire logic erase_boot = ext_chip_erase
        || (ext_block_erase && ext_erase_region == BOOT_REGION);
    wire logic [LOW_W-1:0] erase_low = ext_chip_erase ? 4'hf :
        (ext_block_erase && ext_erase_region < BOOT_REGION)
        ? 4'(4'h1 << ext_erase_region[1:0]) : 4'h0;

    // core table write of a config byte, unless cfg_wr_hi[CFGWR_BIT] locks all of them
    wire logic cfg_locked = !cfg_wr_hi[CFGWR_BIT];
    wire logic core_cfg_wr = (state == PMBP_EXEC) && is_write
                             && cfg_hit(op_addr) && !cfg_locked;
    wire logic ext_cfg_wr = ext_valid && ext_write && cfg_hit(ext_addr);
    wire logic [ADDR_W-1:0] cw_addr = ext_cfg_wr ? ext_addr : op_addr;
    wire logic [DATA_W-1:0] cw_data = ext_cfg_wr ? ext_wdata : mem_wdata;
    wire logic cw_en = ext_cfg_wr || core_cfg_wr;

    logic [DATA_W-1:0] v_ext_lo, v_wr_lo, v_rd_lo;
    // a block erase of regions 0..3 restores only its own region's bits; a boot erase resets the whole high bytes
    assign cfg_ext_lo = v_ext_lo;
    assign cfg_wr_lo = v_wr_lo;
    assign cfg_rd_lo = v_rd_lo;

    logic [DATA_W-1:0] raw_ext_lo, raw_wr_lo, raw_rd_lo;
    pmbp_fuse_reg u_ext_lo (.sys_clk(sys_clk), .reset(reset),
        .wr_en(cw_en && cw_addr == CFG_EXT_LOW), .wr_data(cw_data),
        .erase(1'b0), .mask(LOW_MASK), .value(raw_ext_lo));
    pmbp_fuse_reg u_ext_hi (.sys_clk(sys_clk), .reset(reset),
        .wr_en(cw_en && cw_addr == CFG_EXT_HIGH), .wr_data(cw_data),
        .erase(erase_boot), .mask(EXT_HIGH_MASK), .value(cfg_ext_hi));
    pmbp_fuse_reg u_wr_lo (.sys_clk(sys_clk), .reset(reset),
        .wr_en(cw_en && cw_addr == CFG_WR_LOW), .wr_data(cw_data),
        .erase(1'b0), .mask(LOW_MASK), .value(raw_wr_lo));
    pmbp_fuse_reg u_wr_hi (.sys_clk(sys_clk), .reset(reset),
        .wr_en(cw_en && cw_addr == CFG_WR_HIGH), .wr_data(cw_data),
        .erase(erase_boot), .mask(WR_HIGH_MASK), .value(cfg_wr_hi));
    pmbp_fuse_reg u_rd_lo (.sys_clk(sys_clk), .reset(reset),
        .wr_en(cw_en && cw_addr == CFG_RD_LOW), .wr_data(cw_data),
        .erase(1'b0), .mask(LOW_MASK), .value(raw_rd_lo));
    pmbp_fuse_reg u_rd_hi (.sys_clk(sys_clk), .reset(reset),
        .wr_en(cw_en && cw_addr == CFG_RD_HIGH), .wr_data(cw_data),
        .erase(erase_boot), .mask(RD_HIGH_MASK), .value(cfg_rd_hi));

    // per-region erase overlay: sticky ones since last erase
    logic [LOW_W-1:0] set_ext, set_wr, set_rd;
    // zeros written into a low byte knock down its overlay bits
    wire logic [LOW_W-1:0] clr_ext = (cw_en && cw_addr == CFG_EXT_LOW)
                                     ? ~cw_data[LOW_W-1:0] : 4'h0;
    wire logic [LOW_W-1:0] clr_wr = (cw_en && cw_addr == CFG_WR_LOW)
                                    ? ~cw_data[LOW_W-1:0] : 4'h0;
    wire logic [LOW_W-1:0] clr_rd = (cw_en && cw_addr == CFG_RD_LOW)
                                    ? ~cw_data[LOW_W-1:0] : 4'h0;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            set_ext <= 4'h0;
            set_wr <= 4'h0;
            set_rd <= 4'h0;
        end else begin
            // an erase in the same cycle as a clearing write wins
            set_ext <= (set_ext & ~clr_ext) | erase_low;
            set_wr <= (set_wr & ~clr_wr) | erase_low;
            set_rd <= (set_rd & ~clr_rd) | erase_low;
        end
    end
    assign v_ext_lo = (raw_ext_lo | {4'h0, set_ext}) & LOW_MASK;
    assign v_wr_lo = (raw_wr_lo | {4'h0, set_wr}) & LOW_MASK;
    assign v_rd_lo = (raw_rd_lo | {4'h0, set_rd}) & LOW_MASK;

    // five regions, three settings each
    wire logic [REGIONS-1:0] ext_prot =
        {cfg_ext_hi[BOOT_BIT], cfg_ext_lo[LOW_W-1:0]};
    wire logic [REGIONS-1:0] wr_prot =
        {cfg_wr_hi[BOOT_BIT], cfg_wr_lo[LOW_W-1:0]};
    wire logic [REGIONS-1:0] rd_prot =
        {cfg_rd_hi[BOOT_BIT], cfg_rd_lo[LOW_W-1:0]};

    function automatic logic [DATA_W-1:0] cfg_read(
        input logic [ADDR_W-1:0] a);
        case (a)
            CFG_EXT_LOW: cfg_read = cfg_ext_lo;
            CFG_EXT_HIGH: cfg_read = cfg_ext_hi;
            CFG_WR_LOW: cfg_read = cfg_wr_lo;
            CFG_WR_HIGH: cfg_read = cfg_wr_hi;
            CFG_RD_LOW: cfg_read = cfg_rd_lo;
            CFG_RD_HIGH: cfg_read = cfg_rd_hi;
            DEVID_LOW: cfg_read = DEVICE_ID[7:0];
            DEVID_HIGH: cfg_read = DEVICE_ID[15:8];
            default: cfg_read = 8'h00;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // core table access checks
    // ---------------------------------------------------------------
    wire logic tgt_user = tgt_region != NO_REGION;
    wire logic tgt_special = cfg_hit(op_addr) || op_addr == DEVID_LOW
                             || op_addr == DEVID_HIGH;
    wire logic wr_blocked = tgt_user && !wr_prot[tgt_region];
    // foreign read check uses the executing address of the instruction
    wire logic rd_foreign = tgt_user && !rd_prot[tgt_region]
                            && exec_region != tgt_region;
    // a process, not an assign, so it follows changes of the bytes
    // that cfg_read looks at and not only of its argument
    logic [DATA_W-1:0] core_data;
    always_comb begin
        core_data = tgt_special ? cfg_read(op_addr) :
            (!tgt_user || rd_foreign) ? 8'h00 : mem_rdata;
    end
    wire logic do_prog = (state == PMBP_EXEC) && is_write && tgt_user
                         && !wr_blocked;

    // user-code accesses never consult the external protect bits
    wire logic ext_blocked = ext_region != NO_REGION
                             && !ext_prot[ext_region];
    wire logic ext_cfg_rd = cfg_hit(ext_addr) || ext_addr == DEVID_LOW
                            || ext_addr == DEVID_HIGH;

    // ---------------------------------------------------------------
    // sequencer: two cycles per table op, then optional programming
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            PMBP_IDLE: if (start) next_state = PMBP_EXEC;
            PMBP_EXEC: next_state = do_prog ? PMBP_PROG : PMBP_IDLE;
            PMBP_PROG: if (prog_done) next_state = PMBP_IDLE;
            default: next_state = PMBP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= PMBP_IDLE;
            ptr_mode <= PTR_NONE;
            is_write <= 1'b0;
            op_addr <= '0;
            exec_region <= NO_REGION;
        end else begin
            state <= next_state;
            if (start) begin
                ptr_mode <= mode_in;
                is_write <= is_table_write_instr;
                op_addr <= addr_in;
                exec_region <= pc_region;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tbl_rdata <= '0;
            tbl_rdone <= 1'b0;
            tbl_ptr_next <= '0;
            tbl_ptr_load <= 1'b0;
            tbl_wr_refused <= 1'b0;
            mem_prog <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
            ext_rdata <= '0;
            ext_rdone <= 1'b0;
            ext_refused <= 1'b0;
            busy <= 1'b0;
        end else begin
            tbl_rdone <= (state == PMBP_EXEC) && !is_write;
            tbl_rdata <= (state == PMBP_EXEC && !is_write)
                         ? core_data : tbl_rdata;
            tbl_ptr_load <= state == PMBP_EXEC;
            tbl_ptr_next <= (ptr_mode == PTR_PREINC) ? op_addr
                            : step_ptr(op_addr, ptr_mode);
            tbl_wr_refused <= (state == PMBP_EXEC) && is_write
                && (wr_blocked || (cfg_hit(op_addr) && cfg_locked));
            mem_prog <= next_state == PMBP_PROG;
            if (start) begin
                mem_addr <= addr_in;
                mem_wdata <= tbl_wdata;
            end
            ext_rdone <= ext_valid && !ext_write;
            ext_refused <= ext_valid && ext_blocked;
            ext_rdata <= (ext_valid && !ext_write)
                ? (ext_cfg_rd ? cfg_read(ext_addr) :
                   (ext_blocked || ext_region == NO_REGION) ? 8'h00
                   : mem_rdata) : ext_rdata;
            busy <= next_state != PMBP_IDLE || erase_any;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_wr_refused: assert property (
        @(posedge sys_clk) disable iff (reset)
        state == PMBP_EXEC && is_write && wr_blocked
        |=> !mem_prog && tbl_wr_refused)
        else $error("protected table write started programming");
    a_foreign_zero: assert property (
        @(posedge sys_clk) disable iff (reset)
        state == PMBP_EXEC && !is_write && rd_foreign
        |=> tbl_rdone && tbl_rdata == 8'h00)
        else $error("foreign read leaked data");
    a_own_read: assert property (
        @(posedge sys_clk) disable iff (reset)
        state == PMBP_EXEC && !is_write && tgt_user && !rd_foreign
        |=> tbl_rdata == $past(mem_rdata))
        else $error("same-region read did not return memory");
    a_two_cycle: assert property (
        @(posedge sys_clk) disable iff (reset)
        start |=> state == PMBP_EXEC ##1 state != PMBP_EXEC)
        else $error("table op not two cycles");
    a_prog_holds: assert property (
        @(posedge sys_clk) disable iff (reset)
        mem_prog && !prog_done |=> mem_prog)
        else $error("programming dropped before done");
    a_unimpl_zero: assert property (
        @(posedge sys_clk) disable iff (reset)
        state == PMBP_EXEC && !tgt_user && !tgt_special
        |=> !mem_prog && (is_write || tbl_rdata == 8'h00))
        else $error("unimplemented space touched");
    a_ext_block: assert property (
        @(posedge sys_clk) disable iff (reset)
        ext_valid && !ext_write && ext_blocked && !ext_cfg_rd
        |=> ext_rdata == 8'h00 && ext_refused)
        else $error("protected region visible to programmer");
    a_boot_size: assert property (
        @(posedge sys_clk) disable iff (reset)
        op_addr == BOOT_END |-> tgt_region == BOOT_REGION)
        else $error("boot region bound wrong");
    a_no_raise: assert property (
        @(posedge sys_clk) disable iff (reset)
        !erase_any |=> (wr_prot & ~$past(wr_prot)) == 5'h00)
        else $error("write protect rose without erase");
    a_id_read: assert property (
        @(posedge sys_clk) disable iff (reset)
        state == PMBP_EXEC && !is_write && op_addr == DEVID_LOW
        |=> tbl_rdata == DEVICE_ID[7:0])
        else $error("identification byte not returned");
    a_wr_decode: assert property (
        @(posedge sys_clk) disable iff (reset)
        start && is_table_write_instr |=> state == PMBP_EXEC && is_write)
        else $error("table write opcode not taken");
    a_chip_erase: assert property (
        @(posedge sys_clk) disable iff (reset)
        ext_chip_erase |=> ext_prot == '1 && wr_prot == '1
            && rd_prot == '1)
        else $error("chip erase left a setting cleared");
    a_busy_prog: assert property (
        @(posedge sys_clk) disable iff (reset)
        mem_prog |-> busy)
        else $error("programming while not busy");
    a_cfg_locked: assert property (
        @(posedge sys_clk) disable iff (reset)
        state == PMBP_EXEC && is_write && cfg_hit(op_addr) && cfg_locked
        |=> tbl_wr_refused && !mem_prog)
        else $error("locked configuration byte accepted a write");
endmodule

// ---- bench/pmbp_flash_model.sv ----
// flash array model: combinational read data and a timed programming cycle
module pmbp_flash_model
    import pmbp_pkg::*;
#(
    parameter int PROG_CYCLES = 6
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // address sources
    input wire logic ext_valid,
    input wire logic [pmbp_pkg::ADDR_W-1:0] ext_addr,
    input wire logic [pmbp_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_prog,
    // array answers
    output logic [pmbp_pkg::DATA_W-1:0] mem_rdata,
    output logic prog_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    logic [21:0] sel_addr;
    assign sel_addr = ext_valid ? ext_addr : mem_addr;
    // address-dependent pattern so a stale or zeroed byte is noticed
    assign mem_rdata = sel_addr[7:0] ^ sel_addr[15:8] ^ 8'h3c;
    // one done pulse per cycle; the array never ends programming early
    always_ff @(posedge sys_clk) begin
        if (reset || !mem_prog) begin
            cnt <= 8'h00;
            prog_done <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
            prog_done <= (cnt == 8'(PROG_CYCLES - 1));
        end
    end
endmodule

// ---- bench/tb_top.sv ----
// self-checking testbench for the table access protection logic
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmbp_pkg::*;
    logic sys_clk, reset, large_mem, instr_valid, prog_done;
    logic ext_valid, ext_write, ext_chip_erase, ext_block_erase;
    logic [15:0] instr;
    logic [21:0] pc, tbl_ptr, ext_addr, tbl_ptr_next, mem_addr;
    logic [7:0] tbl_wdata, mem_rdata, ext_wdata;
    logic [7:0] tbl_rdata, mem_wdata, ext_rdata;
    logic [2:0] ext_erase_region;
    logic tbl_rdone, tbl_ptr_load, tbl_wr_refused, mem_prog;
    logic ext_rdone, ext_refused, busy;
    int n_fail = 0;
    int checks = 0;
    pmbp_core pmbp_core_i (.sys_clk(sys_clk), .reset(reset),
        .large_mem(large_mem), .instr_valid(instr_valid), .instr(instr),
        .pc(pc), .tbl_ptr(tbl_ptr), .tbl_wdata(tbl_wdata),
        .mem_rdata(mem_rdata), .prog_done(prog_done),
        .ext_valid(ext_valid), .ext_write(ext_write), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_chip_erase(ext_chip_erase),
        .ext_block_erase(ext_block_erase),
        .ext_erase_region(ext_erase_region), .tbl_rdata(tbl_rdata),
        .tbl_rdone(tbl_rdone), .tbl_ptr_next(tbl_ptr_next),
        .tbl_ptr_load(tbl_ptr_load), .tbl_wr_refused(tbl_wr_refused),
        .mem_prog(mem_prog), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .ext_rdata(ext_rdata), .ext_rdone(ext_rdone),
        .ext_refused(ext_refused), .busy(busy));
    pmbp_flash_model pmbp_flash_model_i (.sys_clk(sys_clk), .reset(reset),
        .ext_valid(ext_valid), .ext_addr(ext_addr), .mem_addr(mem_addr),
        .mem_prog(mem_prog), .mem_rdata(mem_rdata), .prog_done(prog_done));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] pat(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // outputs of the op are settled on return (one edge after the take)
    task automatic core_op(input logic [15:0] op, input logic [21:0] p,
            input logic [21:0] ptr, input logic [7:0] wd);
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr <= op;
        pc <= p;
        tbl_ptr <= ptr;
        tbl_wdata <= wd;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic core_rd(input logic [21:0] p, input logic [21:0] a,
            input logic [7:0] exp);
        core_op(16'h0008, p, a, 8'h00);
        chk(tbl_rdone, 1);
        chk(tbl_rdata, exp);
    endtask
    task automatic ext_op(input logic wr, input logic [21:0] a,
            input logic [7:0] wd);
        @(posedge sys_clk);
        ext_valid <= 1'b1;
        ext_write <= wr;
        ext_addr <= a;
        ext_wdata <= wd;
        @(posedge sys_clk);
        ext_valid <= 1'b0;
        #1;
    endtask
    task automatic ext_rd(input logic [21:0] a, input logic [7:0] exp,
            input logic rf);
        ext_op(1'b0, a, 8'h00);
        chk(ext_rdone, 1);
        chk(ext_rdata, exp);
        chk(ext_refused, rf);
    endtask
    task automatic erase(input logic chip, input logic [2:0] r);
        @(posedge sys_clk);
        ext_chip_erase <= chip;
        ext_block_erase <= !chip;
        ext_erase_region <= r;
        @(posedge sys_clk);
        ext_chip_erase <= 1'b0;
        ext_block_erase <= 1'b0;
        @(posedge sys_clk);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_ptr_modes;
        logic [21:0] nx [4];
        nx = '{22'h002000, 22'h002001, 22'h001fff, 22'h002001};
        for (int m = 0; m < 4; m++) begin
            core_op(16'h0008 | 16'(m), 22'h000100, 22'h002000, 8'h00);
            chk(tbl_rdone, 1);
            chk(tbl_rdata, pat(m == 3 ? 22'h002001 : 22'h002000));
            chk(tbl_ptr_load, 1);
            chk(tbl_ptr_next, nx[m]);
        end
    endtask
    task automatic t_foreign;
        ext_op(1'b1, CFG_RD_LOW, 8'h0e);
        core_rd(22'h002000, 22'h001fff, 8'h00);
        core_rd(22'h001ffe, 22'h001fff, pat(22'h001fff));
        core_rd(22'h000100, 22'h002000, pat(22'h002000));
        ext_op(1'b1, CFG_RD_LOW, 8'h0f);
        ext_rd(CFG_RD_LOW, 8'h0e, 1'b0);
        ext_op(1'b1, CFG_RD_HIGH, 8'h00);
        core_rd(22'h000200, 22'h0001ff, 8'h00);
        core_rd(22'h0001fe, 22'h0001ff, pat(22'h0001ff));
    endtask
    task automatic t_write_prot;
        ext_op(1'b1, CFG_WR_LOW, 8'h0d);
        for (int m = 0; m < 4; m++) begin
            core_op(16'h000c | 16'(m), 22'h000100, 22'h002000, 8'ha5);
            chk(tbl_wr_refused, 1);
            chk(mem_prog, 0);
        end
        core_op(16'h000c, 22'h000100, CFG_WR_LOW, 8'h07);
        chk(tbl_wr_refused, 0);
        ext_rd(CFG_WR_LOW, 8'h05, 1'b0);
        core_op(16'h000c, 22'h000100, CFG_WR_HIGH, 8'hc0);
        core_op(16'h000c, 22'h000100, CFG_WR_LOW, 8'h00);
        chk(tbl_wr_refused, 1);
        ext_rd(CFG_WR_LOW, 8'h05, 1'b0);
    endtask
    task automatic t_prog;
        int n;
        @(posedge sys_clk);
        large_mem <= 1'b1;
        core_op(16'h000d, 22'h000100, 22'h004000, 8'ha5);
        chk(mem_prog, 1);
        chk(tbl_wr_refused, 0);
        chk(mem_addr, 22'h004000);
        chk(mem_wdata, 8'ha5);
        chk(tbl_ptr_next, 22'h004001);
        chk(busy, 1);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(mem_prog, 1);
        n = 0;
        while (mem_prog !== 1'b0 && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(mem_prog, 0);
    endtask
    task automatic t_ext_prot;
        ext_op(1'b1, CFG_EXT_LOW, 8'h07);
        ext_rd(22'h006000, 8'h00, 1'b1);
        ext_op(1'b1, 22'h006000, 8'h00);
        chk(ext_refused, 1);
        core_rd(22'h000100, 22'h006000, pat(22'h006000));
        erase(1'b0, 3'h3);
        ext_rd(CFG_EXT_LOW, 8'h0f, 1'b0);
        ext_rd(22'h006000, pat(22'h006000), 1'b0);
    endtask
    task automatic t_unimpl;
        @(posedge sys_clk);
        large_mem <= 1'b0;
        core_rd(22'h000100, 22'h004000, 8'h00);
        core_rd(22'h000100, DEVID_LOW, DEVICE_ID[7:0]);
        core_rd(22'h000100, CFG_EXT_HIGH, 8'hc0);
        erase(1'b1, 3'h0);
        ext_rd(CFG_RD_LOW, 8'h0f, 1'b0);
        ext_rd(CFG_RD_HIGH, 8'h40, 1'b0);
        ext_rd(CFG_WR_LOW, 8'h0f, 1'b0);
    endtask
    // ---------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        {reset, large_mem} = 2'b11;
        {instr_valid, ext_valid, ext_write} = 3'b000;
        {ext_chip_erase, ext_block_erase} = 2'b00;
        {instr, pc, tbl_ptr, tbl_wdata} = '0;
        {ext_addr, ext_wdata, ext_erase_region} = '0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        ext_rd(CFG_EXT_LOW, 8'h0f, 1'b0);
        ext_rd(CFG_WR_HIGH, 8'he0, 1'b0);
        t_ptr_modes();
        t_foreign();
        t_write_prot();
        t_prog();
        t_ext_prot();
        t_unimpl();
        stop_test();
    end
    // whole run is about 120 cycles; this bound only cuts a hang
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        stop_test();
    end
endmodule
